//--- verilog/bhr_defines.svh
// named offsets, timing counts and reset values of the bus hold and reset sequencer
`ifndef BHR_DEFINES_SVH
`define BHR_DEFINES_SVH

// ****************************************************************
// clock periods in ns
// ****************************************************************
`define BHR_REF_NS           5
`define BHR_DBL_NS           5

// ****************************************************************
// times in double-rate clock periods, and derived cycle counts
// ****************************************************************
`define BHR_WAIT_LOW_PERIODS 8
`define BHR_ST_POW           20
`define BHR_ST_EXTRA_PERIODS 60
`define BHR_INIT_PERIODS     400
`define BHR_WAIT_LOW_CYC     ((`BHR_WAIT_LOW_PERIODS * `BHR_DBL_NS + `BHR_REF_NS - 1) / `BHR_REF_NS)
`define BHR_ST_CYC           ((((1 << `BHR_ST_POW) + `BHR_ST_EXTRA_PERIODS) * `BHR_DBL_NS) / `BHR_REF_NS)
`define BHR_INIT_CYC         ((`BHR_INIT_PERIODS * `BHR_DBL_NS) / `BHR_REF_NS)

// ****************************************************************
// widths and values
// ****************************************************************
`define BHR_CNT_W            21
`define BHR_PRE_W            4
`define BHR_SIG_PASS         32'h00000000
`define BHR_SIG_FAIL         32'hFFFFFFFF
`define BHR_NMI_VECTOR       8'h02
`define BHR_PIN_RST          8'hD8

`endif

//--- verilog/bhr_pkg.sv
// types shared by the bus hold and reset sequencer
package bhr_pkg;

	// ****************************************************************
	// sequencer states, one-hot
	// ****************************************************************
	typedef enum logic [7:0] {
		ST_RESET    = 8'h01,
		ST_ARM      = 8'h02,
		ST_SELFTEST = 8'h04,
		ST_INIT     = 8'h08,
		ST_IDLE     = 8'h10,
		ST_FIRST    = 8'h20,
		ST_T2       = 8'h40,
		ST_GRANT    = 8'h80
	} bhr_state_e;

	// ****************************************************************
	// pins from outside the clock domain (bit 7 first)
	// ****************************************************************
	typedef struct packed {
		logic cop_wait_n;            // coprocessor wait, low active
		logic cop_fault_n;           // coprocessor fault, low active
		logic hold_req;              // bus hold request
		logic ready_n;               // cycle acknowledge, low active
		logic narrow_width_input_n;  // half-width bus response, low active
		logic reset_req;             // system reset pin, high active
		logic nmi;                   // nonmaskable interrupt, edge
		logic operand_xfer_request;  // coprocessor operand request
	} bhr_pins_s;

	// ****************************************************************
	// status toward the processor core
	// ****************************************************************
	typedef struct packed {
		logic selftest_active;
		logic init_active;
		logic cop32_protocol;
		logic nmi_request;
	} bhr_status_s;

endpackage

//--- verilog/bhr_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps

module bhr_sync3 #(
	parameter int             W   = 8,
	parameter logic [W-1:0]   RST = '0
) (
	input  wire logic         ref_clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] raw,
	output logic      [W-1:0] clean
);

	// ****************************************************************
	// one chain per bit; first stage feeds only the second
	// ****************************************************************
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			logic s1;  // metastable catch
			logic s2;  // second stage
			logic s3;  // third stage

			// shift chain
			always_ff @(posedge ref_clk)
			begin
				if (!resetn)
				begin
					s1 <= RST[i];
					s2 <= RST[i];
					s3 <= RST[i];
				end
				else
				begin
					s1 <= raw[i];
					s2 <= s1;
					s3 <= s2;
				end
			end

			// a change counts only once two stable stages agree
			always_ff @(posedge ref_clk)
			begin
				if (!resetn)
					clean[i] <= RST[i];
				else if (s2 == s3)
					clean[i] <= s3;
			end
		end
	endgenerate

endmodule

//--- verilog/bhr_seq.sv
// bus hold grant and reset sequencing for the local processor bus
`timescale 1ns/100ps
`include "bhr_defines.svh"

module bhr_seq #(
	parameter int unsigned ST_CYC = `BHR_ST_CYC  // self-test length, shorten in simulation
) (
	input  wire logic                ref_clk,
	input  wire logic                resetn,
	input  wire bhr_pkg::bhr_pins_s  pins,
	input  wire logic                core_req,
	input  wire logic                core_lock,
	input  wire logic                core_need_upper,
	input  wire logic                core_nmi_taken,
	input  wire logic                coprocessor_opcode,
	input  wire logic                st_fault,
	output logic                     grant_acknowledge,
	output logic                     bus_oe,
	output logic                     addr_strobe,
	output logic                     lock_out,
	output logic                     cycle_done,
	output logic                     proc_clk_en,
	output bhr_pkg::bhr_status_s     status,
	output logic [7:0]               nmi_vector,
	output logic [31:0]              accumulator_reg
);

	// ****************************************************************
	// constants at the widths they meet
	// ****************************************************************
	localparam logic [`BHR_CNT_W-1:0] ST_LAST   = `BHR_CNT_W'(ST_CYC - 1);
	localparam logic [`BHR_CNT_W-1:0] INIT_LAST = `BHR_CNT_W'(`BHR_INIT_CYC - 1);
	localparam logic [`BHR_CNT_W-1:0] ARM_LAST  = `BHR_CNT_W'(`BHR_WAIT_LOW_CYC - 1);
	localparam logic [`BHR_PRE_W-1:0] PRE_FULL  = `BHR_PRE_W'(`BHR_WAIT_LOW_CYC);

	// ****************************************************************
	// declarations
	// ****************************************************************
	bhr_pkg::bhr_pins_s     pc;              // synchronised pins
	bhr_pkg::bhr_state_e    state;           // sequencer state
	bhr_pkg::bhr_state_e    next_state;      // its next value
	logic [`BHR_CNT_W-1:0]  cnt;             // cycles spent in the state
	logic [`BHR_PRE_W-1:0]  pre_cnt;         // wait-low run during reset
	logic                   second_q;        // second half-width cycle running
	logic                   lock_q;          // current cycle is locked
	logic                   nmi_prev;        // last nmi level
	logic                   nmi_pend;        // one remembered nmi edge
	logic                   nmi_rise;        // nmi rising edge this cycle
	logic                   cop32;           // 32-bit coprocessor protocol
	logic                   opcode_seen;     // first coprocessor opcode issued
	logic                   fault_seen;      // self-test engine saw a fault
	logic                   phase;           // processor clock phase
	logic                   rdy;             // cycle acknowledged
	logic                   narrow;          // half-width response
	logic                   in_grant;        // grant state decode

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	bhr_sync3 #(
		.W   (8),
		.RST (`BHR_PIN_RST)
	) u_sync (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.raw     (pins),
		.clean   (pc)
	);

	// ****************************************************************
	// decodes
	// ****************************************************************
	// in grant the acknowledge and narrow pins are never looked at
	assign rdy      = ~pc.ready_n & ~in_grant;
	assign narrow   = ~pc.narrow_width_input_n & ~in_grant;
	assign in_grant = (state == bhr_pkg::ST_GRANT);
	assign nmi_rise = pc.nmi & ~nmi_prev;

	// ****************************************************************
	// next state
	// ****************************************************************
	// reset is checked first so it wins over hold in every state
	always_comb
	begin
		next_state = state;
		if (pc.reset_req)
			next_state = bhr_pkg::ST_RESET;
		else
		begin
			case (state)
				bhr_pkg::ST_RESET:
					// wait held low long enough before the falling edge
					if (pre_cnt == PRE_FULL)
						next_state = bhr_pkg::ST_ARM;
					else
						next_state = bhr_pkg::ST_INIT;
				bhr_pkg::ST_ARM:
					// wait must also stay low after the falling edge
					if (pc.cop_wait_n)
						next_state = bhr_pkg::ST_INIT;
					else if (cnt == ARM_LAST)
						next_state = bhr_pkg::ST_SELFTEST;
				bhr_pkg::ST_SELFTEST:
					// length fixed, outcome does not shorten it
					if (cnt == ST_LAST)
						next_state = bhr_pkg::ST_INIT;
				bhr_pkg::ST_INIT:
					if (cnt == INIT_LAST)
						next_state = bhr_pkg::ST_IDLE;
				bhr_pkg::ST_IDLE:
					// hold is looked at before the first cycle is started
					if (pc.hold_req)
						next_state = bhr_pkg::ST_GRANT;
					else if (core_req)
						next_state = bhr_pkg::ST_FIRST;
				bhr_pkg::ST_FIRST:
					next_state = bhr_pkg::ST_T2;
				bhr_pkg::ST_T2:
					if (rdy)
					begin
						if (narrow && core_need_upper && !second_q)
							next_state = bhr_pkg::ST_FIRST;
						else if (pc.hold_req && !core_lock)
							next_state = bhr_pkg::ST_GRANT;
						else if (core_req)
							next_state = bhr_pkg::ST_FIRST;
						else
							next_state = bhr_pkg::ST_IDLE;
					end
				bhr_pkg::ST_GRANT:
					// only hold and reset end the grant state; core_req picks FIRST or IDLE as the exit
					if (!pc.hold_req)
					begin
						if (core_req)
							next_state = bhr_pkg::ST_FIRST;
						else
							next_state = bhr_pkg::ST_IDLE;
					end
				default:
					next_state = bhr_pkg::ST_RESET;
			endcase
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			state <= bhr_pkg::ST_RESET;
		else
			state <= next_state;
	end

	// ****************************************************************
	// state cycle counter
	// ****************************************************************
	// one shared counter; it restarts on every state change
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			cnt <= '0;
		else if (next_state != state)
			cnt <= '0;
		else
			cnt <= cnt + `BHR_CNT_W'(1);
	end

	// ****************************************************************
	// wait-low run during reset
	// ****************************************************************
	// saturating, so a long reset does not wrap and lose the request
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			pre_cnt <= '0;
		else if (state != bhr_pkg::ST_RESET)
			pre_cnt <= '0;
		else if (pc.cop_wait_n)
			pre_cnt <= '0;
		else if (pre_cnt != PRE_FULL)
			pre_cnt <= pre_cnt + `BHR_PRE_W'(1);
	end

	// ****************************************************************
	// bus cycle bookkeeping
	// ****************************************************************
	// second_q marks the upper half cycle so it is run only once
	always_ff @(posedge ref_clk)
	begin
		if (!resetn || pc.reset_req)
		begin
			second_q <= 1'b0;
			lock_q   <= 1'b0;
		end
		else if (state == bhr_pkg::ST_T2 && rdy)
		begin
			second_q <= narrow && core_need_upper && !second_q;
			lock_q   <= core_lock;
		end
		else if (state == bhr_pkg::ST_IDLE || in_grant)
			lock_q   <= core_lock;
	end

	// ****************************************************************
	// nonmaskable interrupt edge
	// ****************************************************************
	// only one edge is stored; a clear in the same cycle as an edge loses
	always_ff @(posedge ref_clk)
	begin
		if (!resetn || pc.reset_req)
		begin
			nmi_prev <= 1'b0;
			nmi_pend <= 1'b0;
		end
		else
		begin
			nmi_prev <= pc.nmi;
			if (nmi_rise)
				nmi_pend <= 1'b1;
			else if (core_nmi_taken && !in_grant)
				nmi_pend <= 1'b0;
		end
	end

	// ****************************************************************
	// coprocessor protocol detection
	// ****************************************************************
	// sampling stops at the first opcode so later fault levels are ignored
	always_ff @(posedge ref_clk)
	begin
		if (!resetn || pc.reset_req)
		begin
			cop32       <= 1'b0;
			opcode_seen <= 1'b0;
		end
		else
		begin
			if (coprocessor_opcode)
				opcode_seen <= 1'b1;
			if (!opcode_seen && !coprocessor_opcode && pc.cop_wait_n)
				cop32 <= ~pc.cop_fault_n;
		end
	end

	// ****************************************************************
	// self-test signature
	// ****************************************************************
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			fault_seen      <= 1'b0;
			accumulator_reg <= `BHR_SIG_PASS;
		end
		else if (state == bhr_pkg::ST_RESET)
			fault_seen <= 1'b0;
		else if (state == bhr_pkg::ST_SELFTEST)
		begin
			if (st_fault)
				fault_seen <= 1'b1;
			// written once at the end, whatever the result
			if (cnt == ST_LAST)
				accumulator_reg <= (fault_seen || st_fault) ? `BHR_SIG_FAIL : `BHR_SIG_PASS;
		end
	end

	// ****************************************************************
	// processor clock phase
	// ****************************************************************
	// held during reset so the first phase after the fall is known
	always_ff @(posedge ref_clk)
	begin
		if (!resetn || state == bhr_pkg::ST_RESET)
			phase <= 1'b0;
		else
			phase <= ~phase;
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	// both from the state register, so acknowledge and drive swap together
	assign grant_acknowledge      = in_grant;
	assign bus_oe                 = ~in_grant;
	assign addr_strobe            = (state == bhr_pkg::ST_FIRST);
	assign lock_out               = lock_q & (state == bhr_pkg::ST_FIRST || state == bhr_pkg::ST_T2);
	// done only when no upper half cycle is still to follow
	assign cycle_done             = (state == bhr_pkg::ST_T2) & rdy
		& ~(narrow & core_need_upper & ~second_q);
	assign proc_clk_en            = phase;
	assign status.selftest_active = (state == bhr_pkg::ST_SELFTEST);
	assign status.init_active     = (state == bhr_pkg::ST_INIT);
	assign status.cop32_protocol  = cop32;
	assign status.nmi_request     = nmi_pend & ~in_grant;
	assign nmi_vector             = `BHR_NMI_VECTOR;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	chk_grant_floats: assert property (in_grant |-> !bus_oe && grant_acknowledge)
		else $error("bus driven during grant");
	chk_grant_ack_hold: assert property (grant_acknowledge && pc.hold_req && !pc.reset_req
		|=> grant_acknowledge)
		else $error("acknowledge dropped while hold held");
	chk_grant_ignores_ready: assert property (in_grant && pc.hold_req && !pc.reset_req
		|=> !cycle_done && !addr_strobe)
		else $error("bus activity during grant");
	chk_nmi_kept: assert property (in_grant && nmi_rise && !pc.reset_req
		|=> nmi_pend && !status.nmi_request)
		else $error("nmi edge in grant not kept");
	chk_grant_entry: assert property ($rose(grant_acknowledge) |->
		$past(state == bhr_pkg::ST_IDLE || (state == bhr_pkg::ST_T2 && !core_lock)))
		else $error("grant entered mid cycle or locked");
	chk_second_half: assert property (state == bhr_pkg::ST_T2 && rdy && narrow
		&& core_need_upper && !second_q && !pc.reset_req |=> state == bhr_pkg::ST_FIRST)
		else $error("second half cycle skipped");
	chk_hold_release: assert property (in_grant && !pc.hold_req && !pc.reset_req
		|=> !grant_acknowledge && (state == bhr_pkg::ST_IDLE || state == bhr_pkg::ST_FIRST))
		else $error("bad exit from grant");
	chk_reset_wins: assert property (pc.reset_req |=> state == bhr_pkg::ST_RESET
		&& !grant_acknowledge ##1 !phase)
		else $error("reset did not win");
	chk_selftest_end: assert property (status.selftest_active && cnt == ST_LAST
		&& !pc.reset_req |=> status.init_active)
		else $error("self-test end wrong");
	chk_init_len: assert property (status.init_active && cnt != INIT_LAST && !pc.reset_req
		|=> status.init_active)
		else $error("initialisation cut short");
	chk_signature: assert property ($fell(status.selftest_active) && $past(!fault_seen && !st_fault)
		&& $past(!pc.reset_req) |-> accumulator_reg == `BHR_SIG_PASS)
		else $error("pass signature not zero");

	cov_grant_idle: cover property (state == bhr_pkg::ST_IDLE ##1 in_grant);
	cov_grant_cycle: cover property (state == bhr_pkg::ST_T2 ##1 in_grant);
	cov_selftest: cover property (state == bhr_pkg::ST_ARM ##1 status.selftest_active);
	cov_half_width: cover property (second_q && state == bhr_pkg::ST_FIRST);
	cov_nmi_grant: cover property (in_grant && nmi_rise);

endmodule

//--- testbench/bhr_hold_master.sv
// behavioural model of the external master that borrows the local bus
`timescale 1ns/100ps

module bhr_hold_master (
	input  wire logic ref_clk,
	input  wire logic resetn,
	input  wire logic want,
	input  wire logic grant_acknowledge,
	output logic      hold_req,
	output logic      owns_bus
);
	// ****************************************************************
	// request side
	// ****************************************************************
	// a request once raised is kept until the bus was really handed over,
	// so a late wish to give up never leaves the sequencer half granted
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			hold_req <= 1'h0;
		else if (want)
			hold_req <= 1'h1;
		else if (owns_bus)
			hold_req <= 1'h0;
	end

	// the bus counts as ours once acknowledge is seen while requesting
	always_ff @(posedge ref_clk)
	begin
		if (!resetn || !hold_req)
			owns_bus <= 1'h0;
		else if (grant_acknowledge)
			owns_bus <= 1'h1;
	end
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the bus hold and reset sequencer
`timescale 1ns/100ps

module tb_top;
	// ****************************************************************
	// stimulus and observed signals
	// ****************************************************************
	logic               ref_clk;
	logic               resetn;
	bhr_pkg::bhr_pins_s drv;        // pins as driven by the bench
	bhr_pkg::bhr_pins_s pins;       // pins with the master's hold merged in
	logic               core_req;
	logic               core_lock;
	logic               core_need_upper;
	logic               core_nmi_taken;
	logic               st_fault;
	logic               want;       // bench asks the master for the bus
	logic               hold_req;
	logic               grant_acknowledge;
	logic               bus_oe;
	logic               addr_strobe;
	logic               lock_out;
	logic               coprocessor_opcode;
	logic               cycle_done;
	logic               proc_clk_en;
	bhr_pkg::bhr_status_s status;
	logic [7:0]         nmi_vector;
	logic [31:0]        accumulator_reg;
	int                 failures;
	int                 check_count;

	always_comb
	begin
		pins = drv;
		pins.hold_req = hold_req;
	end

	// short self-test keeps the run brief
	bhr_seq #(.ST_CYC(40)) dut (
		.ref_clk(ref_clk), .resetn(resetn), .pins(pins), .core_req(core_req),
		.core_lock(core_lock), .core_need_upper(core_need_upper),
		.core_nmi_taken(core_nmi_taken), .coprocessor_opcode(coprocessor_opcode),
		.st_fault(st_fault),
		.grant_acknowledge(grant_acknowledge), .bus_oe(bus_oe), .addr_strobe(addr_strobe),
		.lock_out(lock_out), .cycle_done(cycle_done), .proc_clk_en(proc_clk_en), .status(status),
		.nmi_vector(nmi_vector), .accumulator_reg(accumulator_reg)
	);

	bhr_hold_master master (
		.ref_clk(ref_clk), .resetn(resetn), .want(want),
		.grant_acknowledge(grant_acknowledge), .hold_req(hold_req), .owns_bus()
	);

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// wait for grant acknowledge to reach a level, bounded
	task automatic wait_ack(input logic lvl, input int lim);
		for (int n = 0; n < lim && grant_acknowledge !== lvl; n++)
			@(negedge ref_clk);
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	// full reset, optional self-test; flt drives the fault pin for the protocol and st_fault for the test result
	task automatic do_reset(input logic st, input logic flt);
		int   ninit;
		logic sawst;
		logic ph;
		ninit = 0;
		sawst = 1'h0;
		@(posedge ref_clk);
		resetn <= 1'h0;
		drv.reset_req <= 1'h1;
		drv.cop_wait_n <= !st;
		drv.cop_fault_n <= 1'h1;
		st_fault <= flt;
		repeat (4) @(posedge ref_clk);
		resetn <= 1'h1;
		repeat (st ? 80 : 16) @(posedge ref_clk);
		@(negedge ref_clk);
		check("phase in reset", 0, proc_clk_en);
		@(posedge ref_clk);
		drv.reset_req <= 1'h0;
		repeat (12) @(posedge ref_clk);
		drv.cop_wait_n <= 1'h1;
		drv.cop_fault_n <= !flt;
		for (int n = 0; n < 800 && !(ninit > 0 && status.init_active === 1'h0); n++)
		begin
			@(negedge ref_clk);
			sawst = sawst | status.selftest_active;
			if (status.init_active === 1'h1)
				ninit++;
		end
		check("self-test run", st, sawst);
		check("init length", 1, ninit >= 350 && ninit <= 450);
		check("wide protocol", flt, status.cop32_protocol);
		if (st)
			check("fault signature", flt, accumulator_reg !== 32'h0);
		// after the first opcode the fault pin no longer steers the protocol
		@(posedge ref_clk);
		coprocessor_opcode <= 1'h1;
		@(posedge ref_clk);
		coprocessor_opcode <= 1'h0;
		drv.cop_fault_n <= flt;
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
		check("protocol frozen", flt, status.cop32_protocol);
		ph = proc_clk_en;
		@(negedge ref_clk);
		check("phase toggles", !ph, proc_clk_en);
	endtask

	// grant from idle, ignored inputs, one nmi edge, release into a cycle
	task automatic hold_idle;
		logic seen;
		seen = 1'h0;
		@(posedge ref_clk);
		want <= 1'h1;
		wait_ack(1'h1, 12);
		@(posedge ref_clk);
		core_req <= 1'h1;
		drv.ready_n <= 1'h0;
		drv.nmi <= 1'h1;
		repeat (20)
		begin
			@(negedge ref_clk);
			seen = seen | addr_strobe | bus_oe | !grant_acknowledge | status.nmi_request;
		end
		check("quiet grant", 0, seen);
		@(posedge ref_clk);
		want <= 1'h0;
		drv.nmi <= 1'h0;
		wait_ack(1'h0, 12);
		check("drive with ack low", 1, bus_oe);
		check("first state after grant", 1, addr_strobe);
		check("nmi kept", 1, status.nmi_request);
		check("nmi vector", 8'h02, nmi_vector);
		@(posedge ref_clk);
		core_req <= 1'h0;
		core_nmi_taken <= 1'h1;
		@(posedge ref_clk);
		core_nmi_taken <= 1'h0;
		drv.ready_n <= 1'h1;
		repeat (8) @(posedge ref_clk);
	endtask

	// hold raised in a waited cycle; locked or half-width cycles go first
	task automatic hold_mid(input logic lk, input logic nw);
		int   extra;
		logic early;
		logic hit;
		logic done1;
		logic lkseen;
		lkseen = 1'h0;
		extra = 0;
		early = 1'h0;
		hit = 1'h0;
		done1 = 1'h0;
		@(posedge ref_clk);
		core_req <= 1'h1;
		core_lock <= lk;
		core_need_upper <= nw;
		drv.narrow_width_input_n <= !nw;
		for (int n = 0; n < 12 && addr_strobe !== 1'h1; n++)
			@(negedge ref_clk);
		@(posedge ref_clk);
		want <= 1'h1;
		repeat (8)
		begin
			@(negedge ref_clk);
			early = early | grant_acknowledge;
		end
		check("no grant mid cycle", 0, early);
		@(posedge ref_clk);
		drv.ready_n <= 1'h0;
		core_req <= lk;
		for (int n = 0; n < 30 && grant_acknowledge !== 1'h1; n++)
		begin
			@(posedge ref_clk);
			if (hit)
			begin
				core_req <= 1'h0;
				core_lock <= 1'h0;
				core_need_upper <= 1'h0;
				drv.narrow_width_input_n <= 1'h1;
			end
			@(negedge ref_clk);
			hit = addr_strobe === 1'h1;
			lkseen = lkseen | (lock_out === 1'h1);
			if (hit)
				extra++;
			if (cycle_done === 1'h1 && extra == 0)
				done1 = 1'h1;
		end
		check("grant after cycle", 1, grant_acknowledge);
		check("cycles before grant", lk | nw, extra);
		check("done before second half", !nw, done1);
		check("locked cycle marked", lk, lkseen);
		@(posedge ref_clk);
		want <= 1'h0;
		drv.ready_n <= 1'h1;
		wait_ack(1'h0, 12);
		repeat (8) @(posedge ref_clk);
	endtask

	// reset pin beats a standing hold, then hold wins the first cycle
	task automatic reset_in_hold;
		int strobes;
		strobes = 0;
		@(posedge ref_clk);
		want <= 1'h1;
		wait_ack(1'h1, 12);
		@(posedge ref_clk);
		drv.reset_req <= 1'h1;
		core_req <= 1'h1;
		repeat (6) @(negedge ref_clk);
		check("reset ends grant", 0, grant_acknowledge);
		check("reset drives pins", 1, bus_oe);
		repeat (14) @(posedge ref_clk);
		drv.reset_req <= 1'h0;
		for (int n = 0; n < 600 && grant_acknowledge !== 1'h1; n++)
		begin
			@(negedge ref_clk);
			strobes = strobes + int'(addr_strobe === 1'h1);
		end
		check("grant before first cycle", 1, grant_acknowledge);
		check("no cycle before grant", 0, strobes);
		@(posedge ref_clk);
		want <= 1'h0;
		wait_ack(1'h0, 12);
		check("pending cycle after grant", 1, addr_strobe);
		@(posedge ref_clk);
		core_req <= 1'h0;
		repeat (8) @(posedge ref_clk);
	endtask

	// ****************************************************************
	// clock, watchdog and main sequence
	// ****************************************************************
	initial
	begin
		ref_clk = 1'h0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// whole run needs some 2100 cycles
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		failures++;
		$display("MISMATCH watchdog expected end seen timeout");
		report_and_stop();
	end

	initial
	begin
		failures = 0;
		check_count = 0;
		resetn = 1'h0;
		drv = 8'hD8;
		core_req = 1'h0;
		core_lock = 1'h0;
		core_need_upper = 1'h0;
		core_nmi_taken = 1'h0;
		coprocessor_opcode = 1'h0;
		st_fault = 1'h0;
		want = 1'h0;
		do_reset(1'h0, 1'h0);
		hold_idle();
		hold_mid(1'h0, 1'h0);
		hold_mid(1'h1, 1'h0);
		hold_mid(1'h0, 1'h1);
		reset_in_hold();
		do_reset(1'h1, 1'h1);
		do_reset(1'h1, 1'h0);
		report_and_stop();
	end
endmodule
